// ==== logic/srpa_pkg.sv ====
// Constants for the service request priority and acknowledge block
`default_nettype none
package srpa_pkg;
    // =====================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_GVEC = 8'h04;
    localparam logic [7:0] OFS_MATCH_MDM = 8'h08;
    localparam logic [7:0] OFS_MATCH_TX = 8'h0C;
    localparam logic [7:0] OFS_MATCH_RX = 8'h10;
    localparam logic [7:0] OFS_ACK_MDM = 8'h14;
    localparam logic [7:0] OFS_ACK_TX = 8'h18;
    localparam logic [7:0] OFS_ACK_RX = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // =====================================================
    // Configuration field positions
    localparam int CFG_PKG_KIND = 7;
    localparam int CFG_REG_ACK_EN = 6;
    localparam int CFG_CHAIN_EN = 5;
    localparam int CFG_CROSS_PRI = 4;
    localparam int CFG_FAIR_OVR = 3;
    localparam int CFG_AUTO_PRI = 1;
    localparam int CFG_ORDER_SEL = 0;
    localparam logic [7:0] CFG_WMASK = 8'h7B;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] GVEC_RESET = 8'hFF;
    localparam logic [7:0] MATCH_RESET = 8'h00;
    // =====================================================
    // Acknowledge levels and request bit positions
    typedef enum logic [1:0] {
        SRPA_LVL_NONE = 2'b00,
        SRPA_LVL_MDM = 2'b01,
        SRPA_LVL_TX = 2'b10,
        SRPA_LVL_RX = 2'b11
    } srpa_level_t;
    localparam int REQ_MDM = 0;
    localparam int REQ_TX = 1;
    localparam int REQ_RX = 2;
    // =====================================================
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int PASS_TIME_NS = 100;
    localparam int PASS_CYCLES = (PASS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PASS_CNT_INIT = 4'(PASS_CYCLES);
endpackage
`default_nettype wire

// ==== logic/srpa_arbiter.sv ====
// Selection of the acknowledged request type
`default_nettype none
module srpa_arbiter
    import srpa_pkg::*;
(
    input wire logic automatic_priority,
    input wire logic cross_device_priority,
    input wire logic priority_order_select,
    input wire srpa_pkg::srpa_level_t ack_type,
    input wire logic [2:0] int_req,
    input wire logic [2:0] ext_view,
    output srpa_pkg::srpa_level_t sel_level,
    output logic take
);
    // =====================================================
    // Priority choice
    logic reprio;
    logic [2:0] view;
    srpa_level_t first;
    srpa_level_t second;
    srpa_level_t ranked;
    assign reprio = automatic_priority && (ack_type == SRPA_LVL_MDM);
    assign view = cross_device_priority ? ext_view : int_req;
    assign first = priority_order_select ? SRPA_LVL_TX : SRPA_LVL_RX;
    assign second = priority_order_select ? SRPA_LVL_RX : SRPA_LVL_TX;
    assign ranked = view[2'(first) - 2'd1] ? first :
                    view[2'(second) - 2'd1] ? second :
                    view[REQ_MDM] ? SRPA_LVL_MDM : SRPA_LVL_NONE;
    assign sel_level = reprio ? ranked : ack_type;
    assign take = (sel_level != SRPA_LVL_NONE) && int_req[2'(sel_level) - 2'd1];
endmodule
`default_nettype wire

// ==== logic/srpa_core.sv ====
// Service request priority and acknowledge controller with APB registers
`default_nettype none
module srpa_core
    import srpa_pkg::*;
#(
    parameter logic PKG_KIND = 1'b0
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] int_req,
    input wire logic [2:0] fair_in,
    input wire logic [2:0] ext_req_n,
    input wire logic wire_or_lines,
    input wire logic ack_chain_in_n,
    input wire logic [6:0] ack_addr,
    output logic ack_chain_out_n,
    output logic [2:0] req_out_n,
    output logic [2:0] fair_flags,
    output logic [2:0] external_request_view,
    output logic ack_take,
    output srpa_pkg::srpa_level_t ack_level,
    output logic [7:0] ack_vector
);
    // =====================================================
    // Registers
    logic [7:0] cfg;
    logic [7:0] gvec;
    logic [7:0] match_mdm;
    logic [7:0] match_tx;
    logic [7:0] match_rx;
    logic rdy;
    logic err_q;
    logic pend_take;
    logic pend_pass;
    logic pend_none;
    srpa_level_t pend_level;
    logic hw_pass;
    logic [3:0] pass_cnt;
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic ack_in_prev;

    function automatic srpa_level_t match_type(input logic [7:0] a, input logic [7:0] m_mdm,
                                              input logic [7:0] m_tx, input logic [7:0] m_rx);
        match_type = (a == m_mdm) ? SRPA_LVL_MDM : (a == m_tx) ? SRPA_LVL_TX :
                     (a == m_rx) ? SRPA_LVL_RX : SRPA_LVL_NONE;
    endfunction

    wire reg_ack_en = cfg[CFG_REG_ACK_EN];
    wire chain_en = cfg[CFG_CHAIN_EN];
    wire auto_pri = cfg[CFG_AUTO_PRI];
    wire cross_pri = cfg[CFG_CROSS_PRI];
    wire order_sel = cfg[CFG_ORDER_SEL];

    // =====================================================
    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 12'hFFF;
            sync2 <= 12'hFFF;
        end else begin
            sync1 <= {wire_or_lines, ack_chain_in_n, ack_addr, ext_req_n} ^ 12'h800;
            sync2 <= sync1;
        end
    end
    wire wired = ~sync2[11];
    wire ack_in_s = sync2[10];
    wire [6:0] ack_addr_s = sync2[9:3];
    wire [2:0] ext_asserted = ~sync2[2:0];
    wire [2:0] ext_view = wired ? {3{|ext_asserted}} : ext_asserted;

    // =====================================================
    // Arbitration
    wire hw_start = ack_in_prev && !ack_in_s;
    wire srpa_level_t hw_type = match_type({1'b1, ack_addr_s}, match_mdm, match_tx, match_rx);
    wire srpa_level_t reg_type = (paddr == OFS_ACK_MDM) ? SRPA_LVL_MDM :
                                 (paddr == OFS_ACK_TX) ? SRPA_LVL_TX :
                                 (paddr == OFS_ACK_RX) ? SRPA_LVL_RX : SRPA_LVL_NONE;
    srpa_level_t hw_sel;
    srpa_level_t reg_sel;
    logic hw_take;
    logic reg_take;

    srpa_arbiter u_hw_arb (
        .automatic_priority(auto_pri),
        .cross_device_priority(cross_pri),
        .priority_order_select(order_sel),
        .ack_type(hw_type),
        .int_req(int_req),
        .ext_view(ext_view),
        .sel_level(hw_sel),
        .take(hw_take)
    );

    srpa_arbiter u_reg_arb (
        .automatic_priority(auto_pri),
        .cross_device_priority(cross_pri),
        .priority_order_select(order_sel),
        .ack_type(reg_type),
        .int_req(int_req),
        .ext_view(ext_view),
        .sel_level(reg_sel),
        .take(reg_take)
    );

    // =====================================================
    // APB decode
    wire acc_first = psel && penable && !rdy;
    wire acc_done = psel && penable && rdy;
    wire is_ack = reg_type != SRPA_LVL_NONE;
    wire mapped = is_ack || (paddr == OFS_CONFIG) || (paddr == OFS_GVEC) ||
                  (paddr == OFS_MATCH_MDM) || (paddr == OFS_MATCH_TX) ||
                  (paddr == OFS_MATCH_RX) || (paddr == OFS_STATUS);
    wire reg_ack = acc_first && !pwrite && is_ack && reg_ack_en;
    wire [7:0] vec_take = {gvec[7:3], 1'b0, reg_sel};
    wire [7:0] vec_none = {gvec[7:3], 3'b000};
    wire [7:0] ack_rd = !reg_ack_en ? 8'h00 : reg_take ? vec_take :
                        chain_en ? 8'h00 : vec_none;
    wire [7:0] status = {1'b0, ext_view, 1'b0, int_req};
    wire [7:0] next_rdata = is_ack ? ack_rd :
                            (paddr == OFS_CONFIG) ? {PKG_KIND, cfg[6:0]} :
                            (paddr == OFS_GVEC) ? gvec :
                            (paddr == OFS_MATCH_MDM) ? match_mdm :
                            (paddr == OFS_MATCH_TX) ? match_tx :
                            (paddr == OFS_MATCH_RX) ? match_rx :
                            (paddr == OFS_STATUS) ? status : 8'h00;
    wire wr = acc_done && pwrite && !err_q;

    assign pready = rdy;
    assign pslverr = rdy && err_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy <= 1'b0;
            err_q <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            rdy <= acc_first;
            if (acc_first) begin
                err_q <= !mapped;
                prdata <= {24'h00_0000, pwrite ? 8'h00 : next_rdata};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CFG_RESET;
            gvec <= GVEC_RESET;
            match_mdm <= MATCH_RESET;
            match_tx <= MATCH_RESET;
            match_rx <= MATCH_RESET;
        end else if (wr) begin
            if (paddr == OFS_CONFIG) cfg <= pwdata[7:0] & CFG_WMASK;
            if (paddr == OFS_GVEC) gvec <= pwdata[7:0];
            if (paddr == OFS_MATCH_MDM) match_mdm <= pwdata[7:0];
            if (paddr == OFS_MATCH_TX) match_tx <= pwdata[7:0];
            if (paddr == OFS_MATCH_RX) match_rx <= pwdata[7:0];
        end
    end

    // =====================================================
    // Register acknowledge decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_take <= 1'b0;
            pend_pass <= 1'b0;
            pend_none <= 1'b0;
            pend_level <= SRPA_LVL_NONE;
        end else if (acc_first) begin
            pend_take <= reg_ack && reg_take;
            pend_pass <= reg_ack && !reg_take && chain_en;
            pend_none <= reg_ack && !reg_take && !chain_en;
            pend_level <= reg_sel;
        end
    end

    // =====================================================
    // Acknowledge outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_in_prev <= 1'b1;
            hw_pass <= 1'b0;
            pass_cnt <= 4'h0;
            ack_take <= 1'b0;
            ack_level <= SRPA_LVL_NONE;
            ack_vector <= 8'h00;
            ack_chain_out_n <= 1'b1;
        end else begin
            ack_in_prev <= ack_in_s;
            ack_take <= 1'b0;
            if (hw_start && hw_type != SRPA_LVL_NONE) begin
                ack_take <= hw_take;
                ack_level <= hw_take ? hw_sel : SRPA_LVL_NONE;
                ack_vector <= {gvec[7:3], 1'b0, hw_sel};
                hw_pass <= !hw_take;
            end else if (acc_done && (pend_take || pend_none)) begin
                ack_take <= 1'b1;
                ack_level <= pend_none ? SRPA_LVL_NONE : pend_level;
                ack_vector <= pend_none ? vec_none : {gvec[7:3], 1'b0, pend_level};
            end else if (ack_in_s) begin
                hw_pass <= 1'b0;
            end
            if (acc_done && pend_pass) begin
                pass_cnt <= PASS_CNT_INIT;
            end else if (pass_cnt != 4'h0) begin
                pass_cnt <= pass_cnt - 4'h1;
            end
            ack_chain_out_n <= !((hw_pass && !ack_in_s) || (acc_done && pend_pass) ||
                                 (pass_cnt > 4'h1));
        end
    end

    // =====================================================
    // Request and fairness outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_out_n <= 3'b111;
            fair_flags <= 3'b000;
            external_request_view <= 3'b000;
        end else begin
            req_out_n <= ~int_req;
            fair_flags <= cfg[CFG_FAIR_OVR] ? 3'b111 : fair_in;
            external_request_view <= ext_view;
        end
    end

    // =====================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fair_forced;
        cfg[CFG_FAIR_OVR] |=> fair_flags == 3'b111;
    endproperty
    a_fair_forced: assert property (p_fair_forced) else $error("fair flags not forced");

    property p_fair_pass;
        presetn && !cfg[CFG_FAIR_OVR] |=> fair_flags == $past(fair_in);
    endproperty
    a_fair_pass: assert property (p_fair_pass) else $error("fair flags not passed");

    property p_no_reg_ack;
        acc_first && !pwrite && is_ack && !reg_ack_en
            |=> ##1 (!ack_take || $past(hw_start)) && pass_cnt == 4'h0;
    endproperty
    a_no_reg_ack: assert property (p_no_reg_ack) else $error("ack taken while disabled");

    property p_cfg_reset;
        $rose(presetn) |-> !reg_ack_en;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("enable not reset");

    property p_wired;
        wired && |ext_asserted |=> external_request_view == 3'b111;
    endproperty
    a_wired: assert property (p_wired) else $error("wired view wrong");

    property p_specific;
        auto_pri && hw_start && hw_type == SRPA_LVL_TX && int_req[REQ_TX] && !acc_done
            |=> ack_take && ack_level == SRPA_LVL_TX;
    endproperty
    a_specific: assert property (p_specific) else $error("tx ack reprioritized");

    property p_rx_first;
        auto_pri && !cross_pri && !order_sel && hw_start && hw_type == SRPA_LVL_MDM &&
            int_req[REQ_RX] |=> ack_level == SRPA_LVL_RX;
    endproperty
    a_rx_first: assert property (p_rx_first) else $error("receive not first");

    property p_tx_first;
        auto_pri && !cross_pri && order_sel && hw_start && hw_type == SRPA_LVL_MDM &&
            int_req[REQ_TX] |=> ack_level == SRPA_LVL_TX;
    endproperty
    a_tx_first: assert property (p_tx_first) else $error("transmit not first");

    property p_pass;
        acc_first && reg_ack && !reg_take && chain_en ##1 acc_done |=> !ack_chain_out_n[*3];
    endproperty
    a_pass: assert property (p_pass) else $error("chain not passed");

    property p_none;
        acc_first && reg_ack && !reg_take && !chain_en |=> prdata[2:0] == 3'b000
            ##1 (ack_take || hw_start) && (ack_level == SRPA_LVL_NONE || hw_start);
    endproperty
    a_none: assert property (p_none) else $error("level 00 not taken");

    c_reg_take: cover property (acc_done && pend_take);
    c_reg_pass: cover property (acc_done && pend_pass);
    c_hw_take: cover property (hw_start && hw_take);
    c_hw_pass: cover property (hw_pass && !ack_chain_out_n);
endmodule
`default_nettype wire

// ==== testbench/srpa_peer.sv ====
// Model of the host side driving the hardware acknowledge chain input
`default_nettype none
module srpa_peer (
    input wire logic pclk,
    output logic ack_chain_in_n,
    output logic [6:0] ack_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ack_chain_in_n = 1'b1;
        ack_addr = 7'h00;
    end
    // =====================================================
    // Hardware acknowledge cycle
    // Address picks type
    task automatic hw_ack(input logic [6:0] a);
        @(posedge pclk);
        ack_addr <= a;
        ack_chain_in_n <= 1'b0;
        repeat (10) @(posedge pclk);
        ack_chain_in_n <= 1'b1;
        @(posedge pclk);
        ack_addr <= ~a;
    endtask
endmodule
`default_nettype wire

// ==== testbench/srpa_core_tb.sv ====
// Self-checking bench for the service request acknowledge block
`default_nettype none
module srpa_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import srpa_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wire_or_lines;
    logic ack_chain_in_n, ack_chain_out_n, ack_take, er;
    logic [7:0] paddr, ack_vector;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] int_req, fair_in, ext_req_n, req_out_n, fair_flags, ext_view;
    logic [6:0] ack_addr;
    logic [1:0] last_lvl;
    srpa_level_t ack_level;
    int n_errors, samples_checked, n_take, n_pass;
    // =====================================================
    // Device and chain partner
    srpa_core #(.PKG_KIND(1'b0)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .int_req(int_req), .fair_in(fair_in),
        .ext_req_n(ext_req_n), .wire_or_lines(wire_or_lines), .ack_chain_in_n(ack_chain_in_n),
        .ack_addr(ack_addr), .ack_chain_out_n(ack_chain_out_n), .req_out_n(req_out_n),
        .fair_flags(fair_flags), .external_request_view(ext_view), .ack_take(ack_take),
        .ack_level(ack_level), .ack_vector(ack_vector));
    srpa_peer u_peer (.pclk(pclk), .ack_chain_in_n(ack_chain_in_n), .ack_addr(ack_addr));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // =====================================================
    // Acknowledge monitor
    always @(posedge pclk) begin
        if (ack_take === 1'b1) begin
            n_take++;
            last_lvl = ack_level;
        end
        if (ack_chain_out_n === 1'b0) n_pass++;
    end
    // =====================================================
    // Tasks
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic clr;
        @(negedge pclk);
        n_take = 0;
        n_pass = 0;
    endtask
    // Configure, acknowledge by register read, compare outcome
    task automatic run_ack(input logic [7:0] c, input logic [2:0] r, input logic [7:0] a,
                           input int t, input logic [1:0] l, input int p);
        apb(1'b1, OFS_CONFIG, {24'h0, c});
        int_req <= r;
        clr();
        apb(1'b0, a, 32'h0);
        repeat (8) @(posedge pclk);
        chk(n_take, t);
        chk(n_pass, p);
        chk(req_out_n, {29'h0, ~r});
        if (t == 1) begin
            chk(last_lvl, l);
            chk(rd, {24'h0, 8'hA8 | {6'h0, l}});
            chk(ack_vector, {24'h0, 8'hA8 | {6'h0, l}});
        end
        if (c[CFG_REG_ACK_EN] == 1'b0) chk(rd, 32'h0);
    endtask
    // Configure, acknowledge through the chain pin, compare outcome
    task automatic run_hw(input logic [7:0] c, input logic [2:0] r, input logic [6:0] a,
                          input int t, input logic [1:0] l);
        apb(1'b1, OFS_CONFIG, {24'h0, c});
        int_req <= r;
        clr();
        u_peer.hw_ack(a);
        repeat (4) @(posedge pclk);
        chk(n_take, t);
        if (t == 1) begin
            chk(last_lvl, l);
            chk(ack_vector, {24'h0, 8'hA8 | {6'h0, l}});
        end else begin
            chk(n_pass > 0, 1'b1);
        end
    endtask
    // =====================================================
    // Watchdog
    initial begin
        #(4000 * 25);
        n_errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        tally_and_finish();
    end
    // =====================================================
    // Tests
    initial begin
        n_errors = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        int_req = 3'b000;
        fair_in = 3'b010;
        ext_req_n = 3'b111;
        wire_or_lines = 1'b0;
        repeat (16) @(posedge pclk);
        chk(ack_chain_out_n, 1'b1);
        chk(req_out_n, 3'b111);
        presetn <= 1'b1;
        apb(1'b0, OFS_CONFIG, 32'h0); chk(rd, 32'h0);
        apb(1'b0, OFS_GVEC, 32'h0); chk(rd, 32'hFF);
        apb(1'b0, OFS_MATCH_RX, 32'h0); chk(rd, 32'h0);
        apb(1'b1, OFS_CONFIG, 32'h7B);
        apb(1'b0, OFS_CONFIG, 32'h0); chk(rd, 32'h7B);
        apb(1'b0, 8'h3C, 32'h0); chk(er, 1'b1);
        apb(1'b1, OFS_GVEC, 32'hA8);
        // Fairness override on and off
        apb(1'b1, OFS_CONFIG, 32'h08);
        repeat (3) @(posedge pclk);
        chk(fair_flags, 3'b111);
        apb(1'b1, OFS_CONFIG, 32'h00);
        repeat (3) @(posedge pclk);
        chk(fair_flags, 3'b010);
        // Wire-OR spread of one external request
        ext_req_n <= 3'b110;
        repeat (6) @(posedge pclk);
        chk(ext_view, 3'b001);
        wire_or_lines <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(ext_view, 3'b111);
        wire_or_lines <= 1'b0;
        // Register acknowledges, local mode, modem-only external view
        run_ack(8'h02, 3'b111, OFS_ACK_RX, 0, SRPA_LVL_NONE, 0);
        run_ack(8'h42, 3'b111, OFS_ACK_MDM, 1, SRPA_LVL_RX, 0);
        run_ack(8'h43, 3'b111, OFS_ACK_MDM, 1, SRPA_LVL_TX, 0);
        run_ack(8'h43, 3'b001, OFS_ACK_MDM, 1, SRPA_LVL_MDM, 0);
        run_ack(8'h42, 3'b011, OFS_ACK_MDM, 1, SRPA_LVL_TX, 0);
        run_ack(8'h42, 3'b111, OFS_ACK_TX, 1, SRPA_LVL_TX, 0);
        run_ack(8'h43, 3'b111, OFS_ACK_RX, 1, SRPA_LVL_RX, 0);
        run_ack(8'h40, 3'b010, OFS_ACK_TX, 1, SRPA_LVL_TX, 0);
        run_ack(8'h40, 3'b000, OFS_ACK_RX, 1, SRPA_LVL_NONE, 0);
        run_ack(8'h60, 3'b000, OFS_ACK_RX, 0, SRPA_LVL_NONE, PASS_CYCLES);
        // Cross-device mode ranks on the external view
        ext_req_n <= 3'b011;
        repeat (6) @(posedge pclk);
        run_ack(8'h72, 3'b110, OFS_ACK_MDM, 1, SRPA_LVL_RX, 0);
        run_ack(8'h72, 3'b010, OFS_ACK_MDM, 0, SRPA_LVL_NONE, PASS_CYCLES);
        // Hardware chain with register acknowledges enabled
        apb(1'b1, OFS_MATCH_MDM, 32'hF5);
        apb(1'b1, OFS_MATCH_TX, 32'hF6);
        apb(1'b1, OFS_MATCH_RX, 32'hF7);
        run_hw(8'h60, 3'b100, 7'h77, 1, SRPA_LVL_RX);
        run_hw(8'h60, 3'b000, 7'h77, 0, SRPA_LVL_NONE);
        run_hw(8'h62, 3'b111, 7'h75, 1, SRPA_LVL_RX);
        run_hw(8'h63, 3'b111, 7'h75, 1, SRPA_LVL_TX);
        run_hw(8'h62, 3'b111, 7'h76, 1, SRPA_LVL_TX);
        tally_and_finish();
    end
endmodule
`default_nettype wire
